/* File: hdl/tls_pkg.sv */
// constants and carrier types for the time-slot loop switching core
// Behaviour
// - nonzero connection code drives downstream serial out
// - connection code zero leaves downstream output undriven
// - msb-clear upstream pointer feeds slot from internal downstream
// - port-to-port loop reads upstream data memory back
// - control 0110 0000 writes slot tristate field
// - control 0111 0001 writes full-slot connection entry
// - address msb picks upstream or downstream memory
// - single frame buffer gives zero to one frame delay
package tls_pkg;
  localparam int SLOT_W = 7;
  localparam int DIR_BIT = 7;
  localparam int TS_W = 4;
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0c;
  localparam logic [4:0] OFS_CMRD = 5'h10;
  localparam logic [3:0] MOC_CM = 4'h7;
  localparam logic [3:0] MOC_TS = 4'h6;
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
  localparam logic [3:0] CODE_FULL = 4'h1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [TS_W-1:0] TS_RESET = 4'h0;

  typedef struct packed {
    logic [3:0] code;
    logic [7:0] ptr;
  } tls_cm_s;

  localparam tls_cm_s CM_RESET = '{code: 4'h0, ptr: 8'h00};
endpackage

/* File: hdl/tls_cmem.sv */
// connection memory: one write port, a slot read port, an access read port
`timescale 1ns/100ps
module tls_cmem #(
  parameter int AW = tls_pkg::SLOT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire tls_pkg::tls_cm_s wdata,
  input wire logic [AW-1:0] slot_addr,
  output tls_pkg::tls_cm_s slot_data,
  input wire logic [AW-1:0] acc_addr,
  output tls_pkg::tls_cm_s acc_data
);
  localparam int DEPTH = 2 ** AW;

  tls_pkg::tls_cm_s mem [DEPTH];

  // every entry starts unassigned so the downstream serial output does not drive before programming
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= tls_pkg::CM_RESET;
    end
    else if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign slot_data = mem[slot_addr];
  assign acc_data = mem[acc_addr];
endmodule // tls_cmem

/* File: hdl/tls_switch.sv */
// time-slot switch core with indirect connection memory access
`timescale 1ns/100ps
module tls_switch #(
  parameter int AW = tls_pkg::SLOT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frame_sync,
  input wire logic slot_tick,
  input wire logic [7:0] pcm_rx_data,
  input wire logic [7:0] cfi_rx_data,
  output logic [7:0] pcm_tx_data,
  output logic [7:0] pcm_tx_oe,
  output logic [7:0] downstream_serial_out,
  output logic downstream_serial_oe
);
  localparam int SLOTS = 2 ** AW;

  logic [7:0] mem_access_data_reg;
  logic [7:0] mem_access_address_reg;
  logic [7:0] mem_access_control_reg;
  logic ack_reg;
  logic [AW-1:0] slot_reg;
  logic [AW-1:0] slot_now;
  logic [3:0] ts_mem [SLOTS];
  logic [7:0] ds_dm [SLOTS];
  logic [7:0] us_dm [SLOTS];
  logic bus_req;
  logic take;
  logic ctrl_hit;
  logic op_cm;
  logic op_ts;
  logic ucm_we;
  logic dcm_we;
  tls_pkg::tls_cm_s cm_wdata;
  tls_pkg::tls_cm_s dent;
  tls_pkg::tls_cm_s uent;
  tls_pkg::tls_cm_s dacc;
  tls_pkg::tls_cm_s uacc;
  tls_pkg::tls_cm_s cm_sel;
  logic [7:0] int_dd;
  logic [7:0] us_src;
  logic us_we;
  logic [7:0] pcm_rd;
  logic [7:0] oe_next;

  function automatic logic [7:0] ts_expand(input logic [3:0] ts);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < tls_pkg::TS_W; i++)
      r[2*i +: 2] = {2{ts[i]}};
    return r;
  endfunction

  // one wait cycle per access, answer on the second edge
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign take = bus_req & ack_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~ack_reg;
  end

  assign ctrl_hit = take & avs_write & avs_byteenable[0] &
                    (avs_address == tls_pkg::OFS_CTRL);
  // memory access fires only on the control write itself
  assign op_cm = ctrl_hit & (avs_writedata[7:4] == tls_pkg::MOC_CM);
  assign op_ts = ctrl_hit &
                 (avs_writedata[7:0] == {tls_pkg::MOC_TS, 4'h0});
  assign ucm_we = op_cm & mem_access_address_reg[tls_pkg::DIR_BIT];
  assign dcm_we = op_cm & ~mem_access_address_reg[tls_pkg::DIR_BIT];
  // code 0001 stores a full-slot connection; other codes stored as given
  assign cm_wdata = '{code: avs_writedata[3:0],
                      ptr: mem_access_data_reg};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_access_data_reg <= tls_pkg::REG_RESET;
      mem_access_address_reg <= tls_pkg::REG_RESET;
      mem_access_control_reg <= tls_pkg::REG_RESET;
    end
    else if (take & avs_write & avs_byteenable[0])
    begin
      case (avs_address)
        tls_pkg::OFS_DATA: mem_access_data_reg <= avs_writedata[7:0];
        tls_pkg::OFS_ADDR: mem_access_address_reg <= avs_writedata[7:0];
        tls_pkg::OFS_CTRL: mem_access_control_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  assign cm_sel = mem_access_address_reg[tls_pkg::DIR_BIT] ? uacc : dacc;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    // loaded in the wait cycle so the data stand at the accepting edge
    else if (bus_req & ~ack_reg & avs_read)
    begin
      case (avs_address)
        tls_pkg::OFS_DATA: avs_readdata <= {24'h0, mem_access_data_reg};
        tls_pkg::OFS_ADDR: avs_readdata <= {24'h0, mem_access_address_reg};
        tls_pkg::OFS_CTRL: avs_readdata <= {24'h0, mem_access_control_reg};
        tls_pkg::OFS_STAT: avs_readdata <= {{(32-AW){1'b0}}, slot_reg};
        tls_pkg::OFS_CMRD: avs_readdata <= {20'h0, cm_sel};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // tristate field, reset to all high impedance
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOTS; i++)
        ts_mem[i] <= tls_pkg::TS_RESET;
    end
    else if (op_ts)
    begin
      ts_mem[mem_access_address_reg[AW-1:0]] <=
        mem_access_data_reg[tls_pkg::TS_W-1:0];
    end
  end

  tls_cmem #(.AW(AW)) u_dcm (
    .ref_clk(ref_clk),
    .rst(rst),
    .we(dcm_we),
    .waddr(mem_access_address_reg[AW-1:0]),
    .wdata(cm_wdata),
    .slot_addr(slot_now),
    .slot_data(dent),
    .acc_addr(mem_access_address_reg[AW-1:0]),
    .acc_data(dacc)
  );

  tls_cmem #(.AW(AW)) u_ucm (
    .ref_clk(ref_clk),
    .rst(rst),
    .we(ucm_we),
    .waddr(mem_access_address_reg[AW-1:0]),
    .wdata(cm_wdata),
    .slot_addr(slot_now),
    .slot_data(uent),
    .acc_addr(mem_access_address_reg[AW-1:0]),
    .acc_data(uacc)
  );

  // slot counter, frame_sync marks slot 0
  assign slot_now = frame_sync ? '0 : slot_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      slot_reg <= '0;
    else if (slot_tick)
      slot_reg <= slot_now + 1'b1;
  end

  // pointer msb set reads the upstream memory: port-to-port loop
  assign int_dd = dent.ptr[tls_pkg::DIR_BIT] ? us_dm[dent.ptr[AW-1:0]]
                                             : ds_dm[dent.ptr[AW-1:0]];
  // msb clear feeds upstream from internal downstream output
  assign us_src = uent.ptr[tls_pkg::DIR_BIT] ? cfi_rx_data : int_dd;
  assign us_we = slot_tick & (uent.code != tls_pkg::CODE_UNASSIGNED);
  assign pcm_rd = us_dm[slot_now];
  assign oe_next = ts_expand(ts_mem[slot_now]);

  // one frame buffers: read before write in the same slot
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOTS; i++)
        ds_dm[i] <= tls_pkg::REG_RESET;
    end
    else if (slot_tick)
      ds_dm[slot_now] <= pcm_rx_data;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOTS; i++)
        us_dm[i] <= tls_pkg::REG_RESET;
    end
    else if (us_we)
      us_dm[uent.ptr[AW-1:0]] <= us_src;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      downstream_serial_out <= 8'h00;
      downstream_serial_oe <= 1'b0;
    end
    else if (slot_tick)
    begin
      downstream_serial_out <= int_dd;
      downstream_serial_oe <=
        (dent.code != tls_pkg::CODE_UNASSIGNED);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pcm_tx_data <= 8'h00;
      pcm_tx_oe <= 8'h00;
    end
    else if (slot_tick)
    begin
      pcm_tx_data <= pcm_rd;
      pcm_tx_oe <= oe_next;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_unassigned_quiet: assert property (
    slot_tick && dent.code == 4'h0 |=> !downstream_serial_oe)
    else $error("unassigned slot drove downstream output");

  a_transparent_drive: assert property (
    slot_tick && dent.code != 4'h0 |=> downstream_serial_oe &&
      downstream_serial_out == $past(int_dd))
    else $error("assigned slot did not drive looped data");

  a_loop_feed: assert property (
    us_we && !uent.ptr[7] |=> us_dm[$past(uent.ptr[6:0])] == $past(int_dd))
    else $error("loop pointer did not take internal downstream data");

  a_port_loop: assert property (
    slot_tick && dent.ptr[7] && dent.code != 4'h0 |=>
      downstream_serial_out == $past(us_dm[dent.ptr[6:0]]))
    else $error("port loop not read from upstream memory");

  a_tristate_write: assert property (
    op_ts |=> ts_mem[$past(mem_access_address_reg[6:0])] ==
      $past(mem_access_data_reg[3:0]))
    else $error("tristate field not written");

  a_tristate_pins: assert property (
    slot_tick && ts_mem[slot_now] == 4'h0 |=> pcm_tx_oe == 8'h00)
    else $error("disabled slot not high impedance");

  a_cm_select: assert property (
    op_cm |=> (mem_access_address_reg[7] ? uacc : dacc) ==
      $past(cm_wdata))
    else $error("connection entry not stored in selected memory");

  a_full_code: assert property (
    ctrl_hit && avs_writedata[7:0] == 8'h71 |=> cm_sel.code == 4'h1)
    else $error("full connection code not stored");

  a_ctrl_only: assert property (
    (dcm_we || ucm_we || op_ts) |-> avs_write && ack_reg &&
      avs_address == 5'h08)
    else $error("memory access without control write");

  a_frame_delay: assert property (
    slot_tick |=> pcm_tx_data == $past(pcm_rd))
    else $error("transmit slot not from one frame buffer");
endmodule // tls_switch

/* File: tb/tls_highway_model.sv */
// slot stream source for the PCM highway and configurable serial port
`timescale 1ns/100ps
module tls_highway_model (
  input wire logic ref_clk,
  input wire logic rst,
  output logic frame_sync,
  output logic slot_tick,
  output logic [7:0] pcm_rx_data,
  output logic [7:0] cfi_rx_data,
  output logic [2:0] slot_idx,
  output logic [3:0] frame_idx
);
  logic [1:0] cnt_reg;
  logic [2:0] slot_reg;
  logic [3:0] frame_reg;
  // eight slots a frame, one tick every fourth cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 2'h0;
      slot_reg <= 3'h0;
      frame_reg <= 4'h0;
      slot_tick <= 1'b0;
      frame_sync <= 1'b0;
      slot_idx <= 3'h0;
      frame_idx <= 4'h0;
      pcm_rx_data <= 8'h00;
      cfi_rx_data <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_reg + 2'h1;
      slot_tick <= (cnt_reg == 2'h3);
      if (cnt_reg == 2'h3)
      begin
        slot_idx <= slot_reg;
        frame_idx <= frame_reg;
        frame_sync <= (slot_reg == 3'h0);
        pcm_rx_data <= {frame_reg, 1'b0, slot_reg};
        cfi_rx_data <= {frame_reg, 1'b1, slot_reg};
        slot_reg <= slot_reg + 3'h1;
        if (slot_reg == 3'h7)
          frame_reg <= frame_reg + 4'h1;
      end
      else
      begin
        // data lines carry no slot between ticks
        pcm_rx_data <= ~pcm_rx_data;
        cfi_rx_data <= ~cfi_rx_data;
      end
    end
  end
endmodule // tls_highway_model

/* File: tb/timeslot_loop_switching_bench.sv */
// self-checking bench for the time-slot loop switching core
`timescale 1ns/100ps
module timeslot_loop_switching_bench;
  localparam logic [7:0] CM1 = {tls_pkg::MOC_CM, tls_pkg::CODE_FULL};
  localparam logic [7:0] CM0 = {tls_pkg::MOC_CM, tls_pkg::CODE_UNASSIGNED};
  localparam logic [7:0] TS = {tls_pkg::MOC_TS, 4'h0};
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic frame_sync, slot_tick, downstream_serial_oe;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, frame_idx, f;
  logic [7:0] pcm_rx_data, cfi_rx_data, pcm_tx_data, pcm_tx_oe;
  logic [7:0] downstream_serial_out;
  logic [2:0] slot_idx;
  int error_cnt = 0;
  int n_checks = 0;

  tls_switch dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .frame_sync, .slot_tick, .pcm_rx_data, .cfi_rx_data, .pcm_tx_data,
    .pcm_tx_oe, .downstream_serial_out, .downstream_serial_oe);
  tls_highway_model far (.ref_clk, .rst, .frame_sync, .slot_tick,
    .pcm_rx_data, .cfi_rx_data, .slot_idx, .frame_idx);

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until waitrequest is seen low; read data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 20)
    begin
      error_cnt++;
      complete_run();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic cm(input logic [7:0] d, input logic [7:0] a,
    input logic [7:0] c);
    bus(1'b1, tls_pkg::OFS_DATA, d);
    bus(1'b1, tls_pkg::OFS_ADDR, a);
    bus(1'b1, tls_pkg::OFS_CTRL, c);
  endtask

  task automatic rb(input logic [7:0] a);
    bus(1'b1, tls_pkg::OFS_ADDR, a);
    bus(1'b0, tls_pkg::OFS_CMRD, 8'h00);
  endtask

  task automatic wait_slot(input logic [2:0] k);
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge ref_clk);
      if (slot_tick === 1'b1 && slot_idx === k)
        break;
    end
    if (i == 400)
    begin
      error_cnt++;
      complete_run();
    end
    f = frame_idx;
    #1;
  endtask

  task automatic t_reset();
    check("oe_reset", 32'(pcm_tx_oe), 32'h0);
    check("ds_oe_reset", 32'(downstream_serial_oe), 32'h0);
    bus(1'b0, 5'h14, 8'h00);
    check("unmapped", rd, 32'h0);
  endtask

  task automatic t_regs();
    bus(1'b1, tls_pkg::OFS_DATA, 8'h19);
    rb(8'h12);
    check("entry_no_ctrl", rd, 32'h0);
    bus(1'b1, tls_pkg::OFS_CTRL, CM1);
    rb(8'h12);
    check("down_entry", rd, 32'h119);
    rb(8'h92);
    check("up_entry_clear", rd, 32'h0);
    cm(8'h09, 8'h92, CM1);
    rb(8'h92);
    check("up_entry", rd, 32'h109);
    bus(1'b0, tls_pkg::OFS_CTRL, 8'h00);
    check("ctrl_kept", rd, 32'(CM1));
    rb(8'h12);
    check("down_kept", rd, 32'h119);
  endtask

  task automatic t_pcm_loop();
    cm(8'h03, 8'h04, CM0);
    cm(8'h05, 8'h84, CM1);
    cm(8'h0f, 8'h05, TS);
    wait_slot(3'h0);
    wait_slot(3'h4);
    check("ds_oe_off", 32'(downstream_serial_oe), 32'h0);
    wait_slot(3'h5);
    check("loop_tx", 32'(pcm_tx_data), 32'({f, 1'b0, 3'h3}));
    check("oe_all", 32'(pcm_tx_oe), 32'hff);
    cm(8'h03, 8'h04, CM1);
    wait_slot(3'h0);
    wait_slot(3'h4);
    check("ds_oe_on", 32'(downstream_serial_oe), 32'h1);
    check("ds_out", 32'(downstream_serial_out), 32'({f, 1'b0, 3'h3}));
  endtask

  task automatic t_cfi_loop();
    cm(8'h86, 8'h82, CM1);
    cm(8'h86, 8'h07, CM1);
    cm(8'h00, 8'h05, TS);
    cm(8'h03, 8'h01, CM1);
    cm(8'h05, 8'h01, TS);
    wait_slot(3'h0);
    wait_slot(3'h1);
    check("ds_prev", 32'(downstream_serial_out), 32'({f - 4'h1, 4'h3}));
    check("oe_pairs", 32'(pcm_tx_oe), 32'h33);
    wait_slot(3'h5);
    check("oe_off", 32'(pcm_tx_oe), 32'h0);
    wait_slot(3'h7);
    check("cfi_loop", 32'(downstream_serial_out), 32'({f, 4'ha}));
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial
  begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_pcm_loop();
    t_cfi_loop();
    complete_run();
  end
endmodule // timeslot_loop_switching_bench
